/* File: dv/sar_adc_sequencer_12bit_monitor.sv */
// Checker for the converter sequencer; it watches the top module's ports only.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module sar_adc_sequencer_12bit_monitor
  import sar_adc_pkg::*;
#(
  parameter int unsigned TCY_CYCLES = TCY_OSC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire reg_req_t bus_req,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic portb_analog_default,
  input wire logic device_sleep,
  input wire logic rc_osc_clk,
  input wire logic comp_above,
  input wire analog_ctrl_t analog,
  input wire logic conv_done_flag,
  input wire logic conv_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Write strobes aimed at the two control registers that drive the front end.
  logic wr0;
  logic wr1;
  assign wr0 = bus_req.wr && bus_req.addr == OFS_CTRL0;
  assign wr1 = bus_req.wr && bus_req.addr == OFS_CTRL1;
  // Cycles the go bit has stood high; a real conversion can never be shorter.
  logic [15:0] busy_cnt_reg;
  logic [15:0] busy_cnt_next;
  always_comb begin
    busy_cnt_next = conv_busy ? busy_cnt_reg + 16'h0001 : 16'h0000;
    if (!rst_n) begin
      busy_cnt_next = 16'h0000;
    end
  end
  always_ff @(posedge sys_clk) begin
    busy_cnt_reg <= busy_cnt_next;
  end
  // Expected routing and analog mask for a written control byte.
  function automatic logic [12:0] route_of(input logic [7:0] d);
    route_of = (d[0] && d[5:2] <= CHAN_MAX) ? 13'h0001 << d[5:2] : 13'h0000;
  endfunction
  function automatic logic [12:0] mask_of(input logic [3:0] c);
    mask_of = (c <= 4'h2) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction
  a_route_channel: assert property (
    wr0 |-> ##2 analog.route == route_of($past(bus_req.wdata, 2)))
    else $error("route does not follow the channel code");
  a_mask_code: assert property (
    wr1 |-> ##2 analog.analog_mask == mask_of($past(bus_req.wdata[3:0], 2)))
    else $error("analog mask does not follow the pin code");
  a_ref_select: assert property (
    wr1 |-> ##2 {analog.neg_ref_ext, analog.pos_ref_ext} == $past(bus_req.wdata[5:4], 2))
    else $error("reference selects do not follow the written bits");
  a_go_starts: assert property (
    wr0 && bus_req.wdata[1:0] == 2'b11 && !conv_busy |=> conv_busy)
    else $error("go with enable did not raise busy");
  a_go_needs_en: assert property (
    wr0 && !bus_req.wdata[0] && !conv_busy |=> !conv_busy [*2])
    else $error("conversion started while disabled");
  a_done_on_end: assert property (
    $fell(conv_busy) && !$past(bus_req.wr) |-> conv_done_flag)
    else $error("busy ended without the done flag");
  a_done_holds: assert property (
    conv_done_flag && !(bus_req.wr && bus_req.addr == OFS_STATUS) |=> conv_done_flag)
    else $error("done flag dropped without a software clear");
  a_conv_min_len: assert property (
    $rose(conv_done_flag) && $fell(conv_busy) |-> busy_cnt_reg >= 16'h001a)
    else $error("conversion shorter than thirteen bit periods");
  a_sample_resume: assert property (
    $rose(conv_done_flag) |-> ##[1:3] analog.sampling)
    else $error("sampling did not resume after completion");
  a_sample_stops: assert property (
    $rose(conv_done_flag) |-> !$past(analog.sampling))
    else $error("sampling still on during conversion");
  a_reset_clear: assert property (
    $rose(rst_n) |-> !conv_busy && !conv_done_flag && analog.route == 13'h0000)
    else $error("reset left the converter active");
  c_done: cover property ($rose(conv_done_flag));
  c_abort: cover property ($fell(conv_busy) && !conv_done_flag);
  c_sleep_conv: cover property ($rose(conv_busy) && device_sleep);
endmodule

bind sar_adc_sequencer_12bit sar_adc_sequencer_12bit_monitor #(
  .TCY_CYCLES(TCY_CYCLES)
) u_mon (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .portb_analog_default(portb_analog_default),
  .device_sleep(device_sleep),
  .rc_osc_clk(rc_osc_clk),
  .comp_above(comp_above),
  .analog(analog),
  .conv_done_flag(conv_done_flag),
  .conv_busy(conv_busy)
);

/* File: dv/tb_top.sv */
// Self-checking bench for the converter sequencer.
// Assumes the bench is the only register master and models the comparator itself.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import sar_adc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t bus_req = '0;
  logic [DATA_W-1:0] bus_rdata;
  logic portb_analog_default = 1'b0;
  logic device_sleep = 1'b0;
  logic rc_osc_clk = 1'b0;
  logic comp_above;
  analog_ctrl_t analog;
  logic conv_done_flag;
  logic conv_busy;
  logic [11:0] vin = 12'h000; // Sampled input level seen by the comparator.
  logic [7:0] res_hi = 8'h00; // Last expected result pair.
  logic [7:0] res_lo = 8'h00;
  logic [7:0] exp_q[$]; // Notes of expected read data, oldest first.
  string nm_q[$];
  logic [7:0] e_v;
  logic [7:0] d_v; // Stimulus byte of the main thread, kept apart from the checker's note.
  string n_v;
  logic rd_d = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  logic [2:0] cs_t[8] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h1, 3'h7, 3'h5};

  // A half-LSB offset makes the result independent of how ties are decided.
  assign comp_above = {vin, 1'b1} > {analog.dac_code, 1'b0};

  sar_adc_sequencer_12bit #(
    .TCY_CYCLES(4)
  ) DUT (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .portb_analog_default(portb_analog_default),
    .device_sleep(device_sleep),
    .rc_osc_clk(rc_osc_clk),
    .comp_above(comp_above),
    .analog(analog),
    .conv_done_flag(conv_done_flag),
    .conv_busy(conv_busy)
  );

  always #2 sys_clk = ~sys_clk;
  // The RC oscillator runs free, out of phase with the system clock.
  always #20 rc_osc_clk = ~rc_osc_clk;

  // Read data stand one cycle after the strobe; each is paired with the oldest note.
  always @(posedge sys_clk) begin
    if (rd_d) begin
      e_v = exp_q.pop_front();
      n_v = nm_q.pop_front();
      `CHK(n_v, e_v, bus_rdata)
    end
    rd_d <= bus_req.rd;
  end

  // A hang is cut short well above the expected run of about five thousand cycles.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One strobe cycle, then one idle cycle so a strobe is never driven twice at one edge.
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    acc(1'b0, a, 8'h00);
  endtask

  function automatic logic [12:0] mask_of(input logic [3:0] c);
    mask_of = (c <= 4'h2) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
  endfunction

  // Reset values of the control and status registers, the strap-driven pin code and an unmapped place.
  task automatic regs_reset(input logic [7:0] c1);
    rd(OFS_CTRL0, 8'h00, "ctrl0");
    rd(OFS_CTRL1, c1, "ctrl1");
    rd(OFS_CTRL2, 8'h00, "ctrl2");
    rd(OFS_STATUS, 8'h00, "status");
    rd(3'h6, 8'h00, "unmapped");
    `CHK("mask_rst", c1[0] ? 13'h00ff : 13'h1fff, analog.analog_mask)
  endtask

  // One conversion: timing window, completion flags, result pair and restart of sampling.
  task automatic conv(input logic [2:0] cs, input logic [2:0] aq, input logic fm);
    int n;
    int dv;
    logic [3:0] ch;
    ch = 4'($urandom_range(12));
    vin = 12'($urandom);
    dv = (cs[1:0] == 2'b11) ? 10 : (2 << {cs[1:0], cs[2]});
    wr(OFS_CTRL2, {fm, 1'b0, aq, cs});
    wr(OFS_CTRL0, {2'b00, ch, 2'b11});
    `CHK("busy", 1'b1, conv_busy)
    n = 1;
    while (conv_busy === 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    dv = (acq_t[aq] + 13) * dv - ((dv == 10) ? 6 : -1);
    `CHK("conv_len", 1'b1, n >= dv && n <= dv + 36)
    `CHK("done", 1'b1, conv_done_flag)
    res_hi = fm ? {4'h0, vin[11:8]} : vin[11:4];
    res_lo = fm ? vin[7:0] : {vin[3:0], 4'h0};
    rd(OFS_RES_HI, res_hi, "res_hi");
    rd(OFS_RES_LO, res_lo, "res_lo");
    rd(OFS_CTRL0, {2'b00, ch, 2'b01}, "ctrl0_go");
    `CHK("sampling", 1'b1, analog.sampling)
    wr(OFS_STATUS, 8'h00);
    rd(OFS_STATUS, 8'h00, "status");
    // Two bit periods at the slowest divider are 128 cycles, so the next go finds the block idle.
    repeat (160) @(posedge sys_clk);
  endtask

  initial begin
    void'($urandom(36));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    regs_reset(8'h07);
    // Every pin code and channel code with a random reference pair, read back and seen at the front end.
    for (int i = 0; i < 16; i++) begin
      d_v = {2'b00, 2'($urandom), 4'(i)};
      wr(OFS_CTRL1, d_v);
      rd(OFS_CTRL1, d_v, "ctrl1");
      `CHK("mask", mask_of(4'(i)), analog.analog_mask)
      `CHK("refs", d_v[5:4], {analog.neg_ref_ext, analog.pos_ref_ext})
      wr(OFS_CTRL0, {2'b00, 4'(i), 2'b01});
      rd(OFS_CTRL0, {2'b00, 4'(i), 2'b01}, "ctrl0");
      `CHK("route", (i <= 12) ? 13'h0001 << i : 13'h0000, analog.route)
      d_v = 8'($urandom);
      wr(OFS_CTRL2, d_v);
      rd(OFS_CTRL2, d_v & 8'hbf, "ctrl2");
    end
    wr(OFS_CTRL0, 8'h02);
    `CHK("go_off", 1'b0, conv_busy)
    // Every acquisition code, every clock code but 0 and 4, and both formats; one conversion in sleep.
    for (int i = 0; i < 8; i++) begin
      device_sleep <= (i == 4);
      conv(cs_t[i], 3'(i), i[0]);
    end
    device_sleep <= 1'b0;
    // Abort by clearing go: no done, result untouched, high result byte not writable.
    wr(OFS_CTRL2, 8'h3e);
    wr(OFS_CTRL0, 8'h03);
    repeat (100) @(posedge sys_clk);
    wr(OFS_CTRL0, 8'h01);
    `CHK("abort_busy", 1'b0, conv_busy)
    `CHK("abort_done", 1'b0, conv_done_flag)
    wr(OFS_RES_HI, ~res_hi);
    rd(OFS_RES_HI, res_hi, "res_keep");
    // Reset in mid-conversion with the other strap value.
    wr(OFS_CTRL0, 8'h03);
    repeat (100) @(posedge sys_clk);
    portb_analog_default <= 1'b1;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("rst_busy", 1'b0, conv_busy)
    regs_reset(8'h00);
    rd(OFS_RES_LO, res_lo, "res_rst");
    results();
  end
endmodule

/* File: rtl/sar_adc_pkg.sv */
// Constants, types and helper functions shared by the 12-bit converter sequencer.
// Assumes a single 250 MHz system clock and a plain strobed register port.
// Function
// - Channel code 0..12 routes input, others none
// - Go bit reads one while converting
// - Enable bit switches converter on or off
// - Negative reference from input 2 or ground
// - Positive reference from input 3 or supply
// - Pin config code turns inputs digital downward
// - Pin config resets from analog-default strap
// - Format bit selects right or left justification
// - Acquisition code maps to bit period counts
// - Clock code selects divider or RC clock
// - RC clock adds one instruction cycle delay
// - RC clocked conversions continue during sleep
// - Successive approximation yields twelve bit result
// - Reset restores registers and aborts conversion
// - Completion loads result, clears go, sets flag
// - Result pair keeps contents through reset
// - Programmed acquisition precedes conversion after go
// - Two bit periods between conversion and acquisition
// - Conversion lasts thirteen bit periods
// - Zero acquisition code converts immediately on go
// - Sampling resumes after every completed conversion
package sar_adc_pkg;

  // Widths of the register port and the converter.
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W = 12;
  localparam int unsigned NUM_CH = 13;

  // Register offsets on the plain port.
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h5;

  // Field positions.
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned GO_BIT = 1;
  localparam int unsigned CHAN_LSB = 2;
  localparam int unsigned PCFG_LSB = 0;
  localparam int unsigned POS_REF_BIT = 4;
  localparam int unsigned NEG_REF_BIT = 5;
  localparam int unsigned ADCS_LSB = 0;
  localparam int unsigned ACQT_LSB = 3;
  localparam int unsigned FMT_BIT = 7;
  localparam int unsigned DONE_BIT = 0;

  // Values after reset.
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [3:0] PCFG_RST_ANALOG = 4'h0;
  localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
  localparam logic [2:0] ACQT_RST = 3'h0;
  localparam logic [2:0] ADCS_RST = 3'h0;

  // Highest channel code that routes an input, and highest all-analog pin code.
  localparam logic [3:0] CHAN_MAX = 4'hc;
  localparam logic [3:0] PCFG_ALL_ANALOG_MAX = 4'h2;

  // Cycle counts: bit periods per conversion, settling gap, instruction cycle.
  localparam logic [4:0] CONV_TADS = 5'h0d;
  localparam logic [4:0] GAP_TADS = 5'h02;
  localparam int unsigned TCY_OSC_CYCLES = 4;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_RC_DELAY,
    ST_ACQ,
    ST_CONV,
    ST_GAP
  } seq_state_t;

  // One request on the register port.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Controls handed to the analog front end.
  typedef struct packed {
    logic [NUM_CH-1:0] route;
    logic [NUM_CH-1:0] analog_mask;
    logic neg_ref_ext;
    logic pos_ref_ext;
    logic sampling;
    logic [RES_W-1:0] dac_code;
  } analog_ctrl_t;

  // Oscillator cycles per bit period, minus one, for each clock code.
  function automatic logic [5:0] tad_div_m1(input logic [2:0] sel);
    case (sel)
      3'h0: tad_div_m1 = 6'h01;
      3'h4: tad_div_m1 = 6'h03;
      3'h1: tad_div_m1 = 6'h07;
      3'h5: tad_div_m1 = 6'h0f;
      3'h2: tad_div_m1 = 6'h1f;
      3'h6: tad_div_m1 = 6'h3f;
      default: tad_div_m1 = 6'h01;
    endcase
  endfunction

  // Bit periods of acquisition for each acquisition code.
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h7: acq_tads = 5'h14;
      3'h6: acq_tads = 5'h10;
      3'h5: acq_tads = 5'h0c;
      3'h4: acq_tads = 5'h08;
      3'h3: acq_tads = 5'h06;
      3'h2: acq_tads = 5'h04;
      3'h1: acq_tads = 5'h02;
      default: acq_tads = 5'h00;
    endcase
  endfunction

endpackage

/* File: rtl/sar_adc_sequencer_12bit.sv */
// Register file, bit-period generator and successive-approximation sequencer.
// Assumes the comparator output and the RC oscillator arrive asynchronously,
// and that the sleep indication comes from logic on the system clock.
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sar_adc_sequencer_12bit
  import sar_adc_pkg::*;
#(
  parameter int unsigned TCY_CYCLES = TCY_OSC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire reg_req_t bus_req,
  output logic [DATA_W-1:0] bus_rdata,
  input wire logic portb_analog_default,
  input wire logic device_sleep,
  input wire logic rc_osc_clk,
  input wire logic comp_above,
  output analog_ctrl_t analog,
  output logic conv_done_flag,
  output logic conv_busy
);

  // The delay counter is three bits wide, so one to eight cycles are served.
  initial begin
    if (TCY_CYCLES < 1 || TCY_CYCLES > 8) begin
      $error("TCY_CYCLES must lie between 1 and 8");
    end
  end

  localparam logic [2:0] TCY_LAST = 3'(TCY_CYCLES - 1);

  // Synchroniser chains; bit 0 is the first flop and feeds only bit 1.
  logic [2:0] rc_sync_reg, rc_sync_next;
  logic [2:0] cmp_sync_reg, cmp_sync_next;
  // Filtered levels, updated only while the second and third flops agree.
  logic rc_lvl_reg, rc_lvl_next;
  logic cmp_lvl_reg, cmp_lvl_next;
  // Rising edge of the filtered RC oscillator.
  logic rc_tick;

  // Next values of the synchronisers.
  always_comb begin
    rc_sync_next = {rc_sync_reg[1:0], rc_osc_clk};
    cmp_sync_next = {cmp_sync_reg[1:0], comp_above};
    rc_lvl_next = rc_lvl_reg;
    cmp_lvl_next = cmp_lvl_reg;
    if (rc_sync_reg[1] == rc_sync_reg[2]) begin
      rc_lvl_next = rc_sync_reg[2];
    end
    if (cmp_sync_reg[1] == cmp_sync_reg[2]) begin
      cmp_lvl_next = cmp_sync_reg[2];
    end
    rc_tick = (rc_sync_reg[1] == rc_sync_reg[2]) && rc_sync_reg[2] && !rc_lvl_reg;
  end

  // Registers of the synchronisers.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rc_sync_reg <= 3'h0;
      cmp_sync_reg <= 3'h0;
      rc_lvl_reg <= 1'b0;
      cmp_lvl_reg <= 1'b0;
    end else begin
      rc_sync_reg <= rc_sync_next;
      cmp_sync_reg <= cmp_sync_next;
      rc_lvl_reg <= rc_lvl_next;
      cmp_lvl_reg <= cmp_lvl_next;
    end
  end

  // Control fields.
  logic en_reg, en_next;
  logic go_reg, go_next;
  logic [3:0] chan_reg, chan_next;
  logic neg_reg, neg_next;
  logic pos_reg, pos_next;
  logic [3:0] pcfg_reg, pcfg_next;
  logic fmt_reg, fmt_next;
  logic [2:0] acqt_reg, acqt_next;
  logic [2:0] adcs_reg, adcs_next;
  logic done_reg, done_next;
  // Sequencer state and counters.
  seq_state_t state_reg, state_next;
  logic [5:0] div_reg, div_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [2:0] tcy_reg, tcy_next;
  logic [RES_W-1:0] sar_reg, sar_next;
  logic [RES_W-1:0] bit_reg, bit_next;
  // Read data and the registered analog controls.
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  analog_ctrl_t analog_reg, analog_next;
  // Result pair, deliberately left out of reset.
  logic [DATA_W-1:0] res_hi_reg, res_hi_next;
  logic [DATA_W-1:0] res_lo_reg, res_lo_next;

  // Helper terms.
  logic use_rc;
  logic osc_tick;
  logic tad_tick;
  logic busy;
  logic [RES_W-1:0] sar_dec;
  logic [RES_W-1:0] next_bit;
  logic set_done;
  logic [NUM_CH-1:0] mask_vec;

  // Pin mask: code 3 and above turn inputs digital from input 12 down.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_mask
      assign mask_vec[gi] = (pcfg_reg <= PCFG_ALL_ANALOG_MAX) ||
        ((5'(gi) + {1'b0, pcfg_reg}) < 5'h0f);
    end
  endgenerate

  // Next values of registers, bit-period generator and sequencer.
  always_comb begin
    en_next = en_reg;
    go_next = go_reg;
    chan_next = chan_reg;
    neg_next = neg_reg;
    pos_next = pos_reg;
    pcfg_next = pcfg_reg;
    fmt_next = fmt_reg;
    acqt_next = acqt_reg;
    adcs_next = adcs_reg;
    done_next = done_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    tcy_next = tcy_reg;
    sar_next = sar_reg;
    bit_next = bit_reg;
    res_hi_next = res_hi_reg;
    res_lo_next = res_lo_reg;
    rdata_next = 8'h00;
    set_done = 1'b0;
    sar_dec = (cmp_lvl_reg) ? sar_reg : (sar_reg & ~bit_reg);
    next_bit = bit_reg >> 1;

    // Codes x11 pick the RC clock; otherwise the oscillator is divided.
    use_rc = (adcs_reg[1:0] == 2'h3);
    busy = (state_reg == ST_RC_DELAY) || (state_reg == ST_ACQ) || (state_reg == ST_CONV);
    // The oscillator divider stops in sleep, so only RC clocked work goes on.
    osc_tick = !use_rc && !device_sleep && (div_reg == tad_div_m1(adcs_reg));
    tad_tick = use_rc ? rc_tick : osc_tick;
    // The divider restarts at idle so the first bit period is a whole one.
    if (state_reg == ST_SAMPLE || osc_tick) begin
      div_next = 6'h00;
    end else if (device_sleep || use_rc) begin
      div_next = div_reg;
    end else begin
      div_next = div_reg + 6'h01;
    end

    // Register writes.
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CTRL0: begin
          en_next = bus_req.wdata[EN_BIT];
          // Go only takes while the write also leaves the converter enabled.
          go_next = bus_req.wdata[GO_BIT] && bus_req.wdata[EN_BIT];
          chan_next = bus_req.wdata[CHAN_LSB +: 4];
        end
        OFS_CTRL1: begin
          neg_next = bus_req.wdata[NEG_REF_BIT];
          pos_next = bus_req.wdata[POS_REF_BIT];
          pcfg_next = bus_req.wdata[PCFG_LSB +: 4];
        end
        OFS_CTRL2: begin
          fmt_next = bus_req.wdata[FMT_BIT];
          acqt_next = bus_req.wdata[ACQT_LSB +: 3];
          adcs_next = bus_req.wdata[ADCS_LSB +: 3];
        end
        OFS_STATUS: begin
          done_next = bus_req.wdata[DONE_BIT];
        end
        default: begin
          // Results and unmapped offsets ignore writes.
        end
      endcase
    end

    // Sequencer.
    case (state_reg)
      ST_SAMPLE: begin
        cnt_next = 5'h00;
        tcy_next = 3'h0;
        if (go_reg && en_reg) begin
          if (use_rc) begin
            state_next = ST_RC_DELAY;
          end else if (acqt_reg != 3'h0) begin
            state_next = ST_ACQ;
          end else begin
            state_next = ST_CONV;
            sar_next = '0;
            bit_next = 12'h800;
          end
        end
      end
      ST_RC_DELAY: begin
        // One instruction cycle passes before the RC bit clock is used.
        tcy_next = tcy_reg + 3'h1;
        if (tcy_reg == TCY_LAST) begin
          if (acqt_reg != 3'h0) begin
            state_next = ST_ACQ;
          end else begin
            state_next = ST_CONV;
            sar_next = '0;
            bit_next = 12'h800;
          end
        end
      end
      ST_ACQ: begin
        if (tad_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if ((cnt_reg + 5'h01) == acq_tads(acqt_reg)) begin
            state_next = ST_CONV;
            cnt_next = 5'h00;
            sar_next = '0;
            bit_next = 12'h800;
          end
        end
      end
      ST_CONV: begin
        if (tad_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == 5'h00) begin
            // The first bit period puts the top trial bit on the DAC.
            sar_next = bit_reg;
          end else if (cnt_reg == (CONV_TADS - 5'h01)) begin
            // The last period decides bit 0 and lands the result.
            state_next = ST_GAP;
            cnt_next = 5'h00;
            sar_next = sar_dec;
            set_done = 1'b1;
            go_next = 1'b0;
            if (fmt_reg) begin
              res_hi_next = {4'h0, sar_dec[11:8]};
              res_lo_next = sar_dec[7:0];
            end else begin
              res_hi_next = sar_dec[11:4];
              res_lo_next = {sar_dec[3:0], 4'h0};
            end
          end else begin
            // Keep or drop the bit on trial, then try the next lower one.
            sar_next = sar_dec | next_bit;
            bit_next = next_bit;
          end
        end
      end
      ST_GAP: begin
        // A go written here waits until the settling gap has run out.
        if (tad_tick) begin
          cnt_next = cnt_reg + 5'h01;
          if ((cnt_reg + 5'h01) == GAP_TADS) begin
            state_next = ST_SAMPLE;
          end
        end
      end
      default: begin
        state_next = ST_SAMPLE;
      end
    endcase

    // Clearing go or enable abandons a conversion without touching the result.
    if (busy && (!go_reg || !en_reg)) begin
      state_next = ST_SAMPLE;
      go_next = 1'b0;
    end
    if (!en_next) begin
      go_next = 1'b0;
    end

    // Hardware set wins over a software clear in the same cycle.
    if (set_done) begin
      done_next = 1'b1;
    end

    // Read data stand in the cycle after the read strobe only.
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CTRL0: rdata_next = {2'h0, chan_reg, go_reg, en_reg};
        OFS_CTRL1: rdata_next = {2'h0, neg_reg, pos_reg, pcfg_reg};
        OFS_CTRL2: rdata_next = {fmt_reg, 1'b0, acqt_reg, adcs_reg};
        OFS_RES_HI: rdata_next = res_hi_reg;
        OFS_RES_LO: rdata_next = res_lo_reg;
        OFS_STATUS: rdata_next = {7'h00, done_reg};
        default: rdata_next = 8'h00;
      endcase
    end

    // Analog controls, registered so the front end sees clean levels.
    analog_next.route = '0;
    if (en_reg && chan_reg <= CHAN_MAX) begin
      analog_next.route = NUM_CH'(13'h0001 << chan_reg);
    end
    analog_next.analog_mask = mask_vec;
    analog_next.neg_ref_ext = neg_reg;
    analog_next.pos_ref_ext = pos_reg;
    // Sampling continues at idle, in acquisition and again after each result.
    analog_next.sampling = en_reg && (state_reg != ST_CONV);
    analog_next.dac_code = sar_reg;
  end

  // Registers with reset; reset forces every control field and aborts the sequence.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_reg <= 1'b0;
      go_reg <= 1'b0;
      chan_reg <= CHAN_RST;
      neg_reg <= 1'b0;
      pos_reg <= 1'b0;
      // The strap is static, so the synchronous reset may load it directly.
      pcfg_reg <= portb_analog_default ? PCFG_RST_ANALOG : PCFG_RST_DIGITAL;
      fmt_reg <= 1'b0;
      acqt_reg <= ACQT_RST;
      adcs_reg <= ADCS_RST;
      done_reg <= 1'b0;
      state_reg <= ST_SAMPLE;
      div_reg <= 6'h00;
      cnt_reg <= 5'h00;
      tcy_reg <= 3'h0;
      sar_reg <= '0;
      bit_reg <= '0;
      rdata_reg <= 8'h00;
      analog_reg <= '0;
    end else begin
      en_reg <= en_next;
      go_reg <= go_next;
      chan_reg <= chan_next;
      neg_reg <= neg_next;
      pos_reg <= pos_next;
      pcfg_reg <= pcfg_next;
      fmt_reg <= fmt_next;
      acqt_reg <= acqt_next;
      adcs_reg <= adcs_next;
      done_reg <= done_next;
      state_reg <= state_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      tcy_reg <= tcy_next;
      sar_reg <= sar_next;
      bit_reg <= bit_next;
      rdata_reg <= rdata_next;
      analog_reg <= analog_next;
    end
  end

  // The result pair has no reset, so it survives every reset of the block.
  always_ff @(posedge sys_clk) begin
    res_hi_reg <= res_hi_next;
    res_lo_reg <= res_lo_next;
  end

  // Outputs.
  assign bus_rdata = rdata_reg;
  assign analog = analog_reg;
  assign conv_done_flag = done_reg;
  assign conv_busy = go_reg;

endmodule
